// [reset_seq_pkg.sv]
package reset_seq_pkg;

	// block bit positions in the reset and done vectors; step_mask gives the power-on order
	localparam int NUM_BLOCKS = 17;
	localparam int BLK_ROSC     = 0;
	localparam int BLK_XOSC     = 1;
	localparam int BLK_CLOCKS   = 2;
	localparam int BLK_RESETS   = 3;
	localparam int BLK_BUSFAB   = 4;
	localparam int BLK_ROM      = 5;
	localparam int BLK_SRAM0    = 6;
	localparam int BLK_SRAM5    = 11;
	localparam int BLK_XIP      = 12;
	localparam int BLK_VREG_CR  = 13;
	localparam int BLK_SIO      = 14;
	localparam int BLK_PROC0    = 15;
	localparam int BLK_PROC1    = 16;
	localparam int NUM_STEPS    = 11;

	// register map, word addresses
	localparam logic [3:0] ADDR_FORCE_ON  = 4'h0;
	localparam logic [3:0] ADDR_FORCE_OFF = 4'h1;
	localparam logic [3:0] ADDR_WD_SELECT = 4'h2;
	localparam logic [3:0] ADDR_DONE      = 4'h3;
	localparam logic [3:0] ADDR_BROWNOUT  = 4'h4;
	localparam logic [3:0] ADDR_CHIP_RST  = 4'h5;

	// brown-out register fields and reset values
	localparam int BOD_EN_BIT     = 0;
	localparam int BOD_THRESHOLD_SELECT_LSB   = 4;
	localparam int BOD_THRESHOLD_SELECT_W     = 4;
	localparam logic [3:0] BOD_THRESHOLD_SELECT_RESET = 4'h9;

	// chip reset status fields
	localparam int CR_SUPPLY_BIT  = 8;
	localparam int CR_PIN_BIT     = 16;
	localparam int CR_DEBUG_BIT   = 20;
	localparam int CR_FLAG_BIT    = 24;

	// timing
	localparam int CLK_MHZ        = 25;
	localparam int BOD_ACTIVE_US  = 55;
	localparam int BOD_ENABLE_US  = 35;
	localparam int BOD_PROG_US    = 20;
	localparam int BOD_ACTIVE_CYC = BOD_ACTIVE_US * CLK_MHZ;
	localparam int BOD_ENABLE_CYC = BOD_ENABLE_US * CLK_MHZ;
	localparam int BOD_PROG_CYC   = BOD_PROG_US * CLK_MHZ;
	localparam int DELAY_W        = 11;

endpackage

// [seq_if.sv]
`timescale 1ns/10ps
interface seq_if;
	logic        start;
	logic [10:0] cycles;
	logic        busy;
	logic        done;
	modport ctl (output start, output cycles, input busy, input done);
	modport tmr (input start, input cycles, output busy, output done);
endinterface

// [delay_timer.sv]
`timescale 1ns/10ps
module delay_timer
	import reset_seq_pkg::*;
(
	input  wire logic core_clk, // core clock
	input  wire logic rst_n,    // async reset, active low
	seq_if.tmr        tif       // start and done
);
	logic [DELAY_W-1:0] cnt_q, cnt_d;
	logic               busy_q, busy_d;
	logic               done_q, done_d;

	always_comb begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (tif.start) begin
			// restart wins so a later write always re-times
			cnt_d  = tif.cycles;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (cnt_q <= 11'h001) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 11'h001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign tif.busy = busy_q;
	assign tif.done = done_q;
endmodule

// [sync2.sv]
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         core_clk, // core clock
	input  wire logic         rst_n,    // async reset, active low
	input  wire logic [W-1:0] d,        // asynchronous input
	output logic      [W-1:0] q         // synchronised output
);
	logic [W-1:0] meta_q, meta_d;
	logic [W-1:0] q_q, q_d;

	always_comb begin
		meta_d = d;
		q_d    = meta_q;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q_q    <= '0;
		end else begin
			meta_q <= meta_d;
			q_q    <= q_d;
		end
	end

	assign q = q_q;
endmodule

// [reset_sequencer.sv]
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - after supply reset, detection active after 55 us; other resets after 35 us
// - new threshold applies only after the 20 us programming delay
// - run pin low holds the whole chip in reset
// - release chip reset when run is high and all other sources released
// - debug port reset also sets the debug restart flag
// - last reset cause kept in three bits: supply, pin, debug port
// - never more than one last-cause bit set
// - each block gets its own reset low; returns done high
// - release one step's blocks, wait for all their done, then the next step
// - sequencer and run-domain reset leave reset together once supply and run good
// - run-domain reset is not reasserted when the sequence restarts
// - first step starts ring oscillator; done after stable count
// - crystal oscillator released, not started, done at once
// - clock generators released: ref from ring undivided, sys from ref
// - then resets, chip-reset regs, xip, rom and sram, fabric, sio, processors
// - chip reset status only reset by chip-level reset
// - processor step releases both cores
// - enable bit write disables or re-enables detection; output low when off
// - watchdog restart drops selected done; later blocks reset again
module reset_sequencer
	import reset_seq_pkg::*;
#(
	parameter int NB = NUM_BLOCKS
) (
	input  wire logic          core_clk,         // core clock
	input  wire logic          rst_n,            // async reset, active low
	input  wire logic          supply_ok,        // power-on/brown-out indication, pin domain
	input  wire logic          run_pin,          // external run pin
	input  wire logic          debug_restart,    // rescue debug port restart request
	input  wire logic          watchdog_fire,    // watchdog pulse, core domain
	input  wire logic [NB-1:0] blk_done,         // per-block done, active high, core domain
	input  wire logic [3:0]    reg_addr,         // register word address
	input  wire logic [31:0]   reg_wdata,        // write data
	input  wire logic          reg_wr,           // write strobe
	input  wire logic          reg_rd,           // read strobe
	output logic      [31:0]   reg_rdata,        // read data, cycle after read strobe
	output logic      [NB-1:0] blk_rst_n,        // per-block reset, active low
	output logic               run_rst_n,        // run-domain reset, active low
	output logic               dp_rst_n,         // debug port reset, active low
	output logic               bod_active,       // brown-out detection armed
	output logic [BOD_THRESHOLD_SELECT_W-1:0] bod_threshold, // threshold applied to the detector
	output logic               ref_from_ring,    // ref clock from ring osc, undivided
	output logic               sys_from_ref,     // sys clock from ref clock
	output logic               ring_osc_start    // ring oscillator enable
);
	logic       supply_s, run_s, dbg_s;
	logic [NB-1:0] done_s;

	sync2 #(.W(3)) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        ({supply_ok, run_pin, debug_restart}),
		.q        ({supply_s, run_s, dbg_s})
	);
	assign done_s = blk_done;

	// chip-level reset sources
	logic chip_hold, seq_hold;
	assign chip_hold = !supply_s || !run_s;
	assign seq_hold  = chip_hold || dbg_s;
	seq_if bod_start ();
	seq_if prog_t ();

	// state of chip-level reset logic
	typedef enum logic [2:0] {
		CAUSE_SUPPLY = 3'b001,
		CAUSE_PIN    = 3'b010,
		CAUSE_DEBUG  = 3'b100
	} cause_t;

	logic [2:0] cause_q, cause_d;
	logic       flag_q, flag_d;
	logic       run_rel_q, run_rel_d;
	logic       was_supply_q, was_supply_d;

	always_comb begin
		cause_d      = cause_q;
		flag_d       = flag_q;
		run_rel_d    = run_rel_q;
		was_supply_d = was_supply_q;
		if (!supply_s) begin
			cause_d      = CAUSE_SUPPLY;
			run_rel_d    = 1'b0;
			was_supply_d = 1'b1;
		end else if (!run_s) begin
			cause_d   = CAUSE_PIN;
			run_rel_d = 1'b0;
		end else begin
			run_rel_d = 1'b1;
		end
		if (dbg_s) begin
			cause_d = CAUSE_DEBUG;
			flag_d  = 1'b1;
		end else if (reg_wr && reg_addr == ADDR_CHIP_RST && reg_wdata[CR_FLAG_BIT]) begin
			flag_d = 1'b0;                    // write one clears; set wins above
		end
		if (bod_start.start)
			was_supply_d = 1'b0;
	end

	// this state is reset only by rst_n, never by the sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_q      <= CAUSE_SUPPLY;
			flag_q       <= 1'b0;
			run_rel_q    <= 1'b0;
			was_supply_q <= 1'b1;
		end else begin
			cause_q      <= cause_d;
			flag_q       <= flag_d;
			run_rel_q    <= run_rel_d;
			was_supply_q <= was_supply_d;
		end
	end

	assign run_rst_n = run_rel_q;
	assign dp_rst_n  = run_rel_q;

	// brown-out control
	delay_timer u_bod_t (.core_clk(core_clk), .rst_n(rst_n), .tif(bod_start));
	delay_timer u_prog_t (.core_clk(core_clk), .rst_n(rst_n), .tif(prog_t));

	logic                  bod_en_q, bod_en_d;
	logic                  armed_q, armed_d;
	logic [BOD_THRESHOLD_SELECT_W-1:0] threshold_select_q, threshold_select_d;
	logic [BOD_THRESHOLD_SELECT_W-1:0] thr_q, thr_d;
	logic                  chip_hold_q;
	logic                  bod_wr;
	assign bod_wr = reg_wr && reg_addr == ADDR_BROWNOUT;

	always_comb begin
		bod_en_d = bod_en_q;
		armed_d  = armed_q;
		threshold_select_d   = threshold_select_q;
		thr_d    = thr_q;
		bod_start.start  = 1'b0;
		bod_start.cycles = was_supply_q ? 11'(BOD_ACTIVE_CYC) : 11'(BOD_ENABLE_CYC);
		prog_t.start  = 1'b0;
		prog_t.cycles = 11'(BOD_PROG_CYC);
		if (chip_hold) begin
			bod_en_d = 1'b1;
			armed_d  = 1'b0;
			threshold_select_d   = BOD_THRESHOLD_SELECT_RESET;
			thr_d    = BOD_THRESHOLD_SELECT_RESET;
		end else begin
			if (chip_hold_q)
				bod_start.start = 1'b1;           // register leaves reset
			if (bod_wr) begin
				bod_en_d = reg_wdata[BOD_EN_BIT];
				threshold_select_d   = reg_wdata[BOD_THRESHOLD_SELECT_LSB +: BOD_THRESHOLD_SELECT_W];
				if (!reg_wdata[BOD_EN_BIT])
					armed_d = 1'b0;
				else if (!bod_en_q)
					bod_start.start = 1'b1;       // re-enable delay
				if (reg_wdata[BOD_THRESHOLD_SELECT_LSB +: BOD_THRESHOLD_SELECT_W] != threshold_select_q)
					prog_t.start = 1'b1;
			end
			if (bod_start.done && bod_en_d)
				armed_d = 1'b1;
			if (prog_t.done)
				thr_d = threshold_select_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bod_en_q    <= 1'b1;
			armed_q     <= 1'b0;
			threshold_select_q      <= BOD_THRESHOLD_SELECT_RESET;
			thr_q       <= BOD_THRESHOLD_SELECT_RESET;
			chip_hold_q <= 1'b1;
		end else begin
			bod_en_q    <= bod_en_d;
			armed_q     <= armed_d;
			threshold_select_q      <= threshold_select_d;
			thr_q       <= thr_d;
			chip_hold_q <= chip_hold;
		end
	end

	assign bod_active    = armed_q;
	assign bod_threshold = thr_q;

	// power-on sequencer
	typedef enum logic [2:0] {
		S_HOLD = 3'b001,
		S_WAIT = 3'b010,
		S_RUN  = 3'b100
	} seq_state_t;

	seq_state_t        st_q, st_d;
	logic [3:0]        step_q, step_d;
	logic [NB-1:0]     rel_q, rel_d;
	logic [NB-1:0]     frc_on_q, frc_on_d, frc_off_q, frc_off_d, watchdog_reset_select_q, watchdog_reset_select_d;

	// step masks: which blocks a step releases
	function automatic logic [NB-1:0] step_mask(input logic [3:0] s);
		logic [NB-1:0] m;
		m = '0;
		unique case (s)
			4'd0:    m[BLK_ROSC]    = 1'b1;
			4'd1:    m[BLK_XOSC]    = 1'b1;
			4'd2:    m[BLK_CLOCKS]  = 1'b1;
			4'd3:    m[BLK_RESETS]  = 1'b1;
			4'd4:    m[BLK_VREG_CR] = 1'b1;
			4'd5:    m[BLK_XIP]     = 1'b1;
			4'd6:    m[BLK_SRAM5:BLK_ROM] = '1;
			4'd7:    m[BLK_BUSFAB]  = 1'b1;
			4'd8:    m[BLK_SIO]     = 1'b1;
			4'd9:    m[BLK_PROC1:BLK_PROC0] = 2'b11;
			default: m = '0;
		endcase
		return m;
	endfunction

	logic [NB-1:0] cur_mask, eff_done, drop;
	assign cur_mask = step_mask(step_q);
	assign eff_done = done_s & rel_q;
	// watchdog selected blocks lose their release; done drops
	assign drop     = watchdog_fire ? watchdog_reset_select_q : '0;

	always_comb begin
		st_d      = st_q;
		step_d    = step_q;
		rel_d     = rel_q & ~drop;
		frc_on_d  = frc_on_q;
		frc_off_d = frc_off_q;
		watchdog_reset_select_d   = watchdog_reset_select_q;
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_FORCE_ON:  frc_on_d  = reg_wdata[NB-1:0];
				ADDR_FORCE_OFF: frc_off_d = reg_wdata[NB-1:0];
				ADDR_WD_SELECT: watchdog_reset_select_d   = reg_wdata[NB-1:0];
				default: ;
			endcase
		end
		unique case (st_q)
			S_HOLD: begin
				if (!seq_hold)
					st_d = S_RUN;
			end
			S_RUN: begin
				rel_d  = (rel_q | cur_mask) & ~drop;
				st_d   = S_WAIT;
			end
			S_WAIT: begin
				if (|(cur_mask & drop) || (rel_q & cur_mask) != cur_mask) begin
					st_d = S_RUN;
				end else if ((eff_done & cur_mask) == cur_mask) begin
					if (step_q < 4'(NUM_STEPS - 2)) begin
						step_d = step_q + 4'd1;
						st_d   = S_RUN;
					end
				end
			end
			default: st_d = S_HOLD;
		endcase
		// earliest dropped block restarts the walk from its step
		if (|drop) begin
			for (int s = NUM_STEPS - 2; s >= 0; s--) begin
				if (|(step_mask(4'(s)) & drop) && 4'(s) <= step_q) begin
					step_d = 4'(s);
					st_d   = S_RUN;
				end
			end
			for (int s = 0; s < NUM_STEPS - 1; s++) begin
				if (4'(s) > step_d)
					rel_d = rel_d & ~step_mask(4'(s));
			end
		end
		if (seq_hold) begin
			st_d   = S_HOLD;
			step_d = 4'd0;
			rel_d  = '0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= S_HOLD;
			step_q    <= 4'd0;
			rel_q     <= '0;
			frc_on_q  <= '0;
			frc_off_q <= '0;
			watchdog_reset_select_q   <= '0;
		end else begin
			st_q      <= st_d;
			step_q    <= step_d;
			rel_q     <= rel_d;
			frc_on_q  <= frc_on_d;
			frc_off_q <= frc_off_d;
			watchdog_reset_select_q   <= watchdog_reset_select_d;
		end
	end

	// force-off beats force-on; chip-level reset beats both
	assign blk_rst_n      = seq_hold ? '0 : ((rel_q | frc_on_q) & ~frc_off_q);
	assign ring_osc_start = blk_rst_n[BLK_ROSC];
	assign ref_from_ring  = 1'b1;
	assign sys_from_ref   = 1'b1;

	// register read port
	logic [31:0] rdata_q, rdata_d;
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_FORCE_ON:  rdata_d[NB-1:0] = frc_on_q;
				ADDR_FORCE_OFF: rdata_d[NB-1:0] = frc_off_q;
				ADDR_WD_SELECT: rdata_d[NB-1:0] = watchdog_reset_select_q;
				ADDR_DONE:      rdata_d[NB-1:0] = eff_done;
				ADDR_BROWNOUT: begin
					rdata_d[BOD_EN_BIT] = bod_en_q;
					rdata_d[BOD_THRESHOLD_SELECT_LSB +: BOD_THRESHOLD_SELECT_W] = threshold_select_q;
				end
				ADDR_CHIP_RST: begin
					rdata_d[CR_SUPPLY_BIT] = cause_q[0];
					rdata_d[CR_PIN_BIT]    = cause_q[1];
					rdata_d[CR_DEBUG_BIT]  = cause_q[2];
					rdata_d[CR_FLAG_BIT]   = flag_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end
	assign reg_rdata = rdata_q;
endmodule

// [reset_sequencer_props.sv]
`timescale 1ns/10ps
module reset_sequencer_props
	import reset_seq_pkg::*;
#(
	parameter int NB = NUM_BLOCKS
) (
	input wire logic                  core_clk,       // clock
	input wire logic                  rst_n,          // reset
	input wire logic                  supply_ok,      // in
	input wire logic                  run_pin,        // in
	input wire logic                  debug_restart,  // in
	input wire logic                  watchdog_fire,  // in
	input wire logic [NB-1:0]         blk_done,       // in
	input wire logic [3:0]            reg_addr,       // in
	input wire logic [31:0]           reg_wdata,      // in
	input wire logic                  reg_wr,         // in
	input wire logic                  reg_rd,         // in
	input wire logic [31:0]           reg_rdata,      // out
	input wire logic [NB-1:0]         blk_rst_n,      // out
	input wire logic                  run_rst_n,      // out
	input wire logic                  dp_rst_n,       // out
	input wire logic                  bod_active,     // out
	input wire logic [BOD_THRESHOLD_SELECT_W-1:0] bod_threshold,  // out
	input wire logic                  ref_from_ring,  // out
	input wire logic                  sys_from_ref,   // out
	input wire logic                  ring_osc_start  // out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// two sync stages plus margin before the source must show
	a_pin_hold: assert property (!run_pin [*4] |-> blk_rst_n == '0)
		else $error("blocks released while run pin low");
	a_dbg_hold: assert property (debug_restart [*4] |-> blk_rst_n == '0)
		else $error("blocks released during debug restart");
	a_run_kept: assert property ((run_pin && supply_ok) [*5] |->
		!$fell(run_rst_n) && !$fell(dp_rst_n))
		else $error("run domain reset dropped with supply and pin good");
	a_xosc_after: assert property ($rose(blk_rst_n[BLK_XOSC]) |-> $past(blk_done[BLK_ROSC]))
		else $error("crystal step before ring done");
	a_clk_after: assert property ($rose(blk_rst_n[BLK_CLOCKS]) |->
		$past(blk_done[BLK_XOSC]) && ref_from_ring && sys_from_ref)
		else $error("clock step early or wrong source");
	a_cores_both: assert property ($rose(blk_rst_n[BLK_PROC0]) |-> $rose(blk_rst_n[BLK_PROC1]))
		else $error("cores not released together");
	a_cores_last: assert property ($rose(blk_rst_n[BLK_PROC0]) |-> &blk_rst_n[BLK_SIO:0])
		else $error("cores released before other blocks");
	a_ring_first: assert property ($rose(ring_osc_start) |-> blk_rst_n[NB-1:1] == '0)
		else $error("ring oscillator not first");
	a_bod_off: assert property (reg_wr && reg_addr == ADDR_BROWNOUT &&
		!reg_wdata[BOD_EN_BIT] |=> !bod_active)
		else $error("detection still armed after disable");
	a_thr_wait: assert property (reg_wr && reg_addr == ADDR_BROWNOUT |=>
		$stable(bod_threshold) [*8])
		else $error("threshold applied too early");

	c_all_up: cover property ($rose(blk_rst_n[BLK_PROC1]));
	c_wdog: cover property (watchdog_fire);
	c_bod: cover property ($rose(bod_active));
endmodule

// [block_model.sv]
`timescale 1ns/10ps
module block_model
	import reset_seq_pkg::*;
(
	input  wire logic                  core_clk,  // clock
	input  wire logic                  rst_n,     // reset, active low
	input  wire logic                  slow,      // answer late
	input  wire logic [NUM_BLOCKS-1:0] blk_rst_n, // per-block reset
	output logic      [NUM_BLOCKS-1:0] blk_done   // per-block done
);
	logic [4:0] cnt_q [NUM_BLOCKS];

	// done drops with the block's own reset, so a restart ripples on
	always_ff @(posedge core_clk or negedge rst_n) begin
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			if (!rst_n || !blk_rst_n[i]) begin
				cnt_q[i]    <= '0;
				blk_done[i] <= 1'b0;
			end else begin
				if (cnt_q[i] != 5'h1F) cnt_q[i] <= cnt_q[i] + 5'h01;
				// ring waits a long ripple count, crystal answers at once
				blk_done[i] <= (i == BLK_XOSC) ||
					cnt_q[i] >= (i == BLK_ROSC ? 5'h1E : slow ? 5'h0C : 5'h02);
			end
		end
	end
endmodule

// [reset_sequencer_test.sv]
`timescale 1ns/10ps
module reset_sequencer_test
	import reset_seq_pkg::*;
;
	logic                  core_clk, rst_n, supply_ok, run_pin, debug_restart;
	logic                  watchdog_fire, slow, reg_wr, reg_rd, rd_d;
	logic                  run_rst_n, dp_rst_n, bod_active, ref_from_ring;
	logic                  sys_from_ref, ring_osc_start;
	logic [NUM_BLOCKS-1:0] blk_done, blk_rst_n;
	logic [3:0]            reg_addr, bod_threshold;
	logic [31:0]           reg_wdata, reg_rdata;
	logic [31:0]           exp_q[$];
	int                    err_total, compares, cyc, seed, t0;

	reset_sequencer u_dut (.core_clk, .rst_n, .supply_ok, .run_pin, .debug_restart,
		.watchdog_fire, .blk_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.blk_rst_n, .run_rst_n, .dp_rst_n, .bod_active, .bod_threshold, .ref_from_ring,
		.sys_from_ref, .ring_osc_start);
	block_model u_blocks (.core_clk, .rst_n, .slow, .blk_rst_n, .blk_done);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic end_sim;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wt(input int b);
		for (int i = 0; i < 3000 && blk_rst_n[b] !== 1'b1; i++) @(posedge core_clk);
	endtask

	task automatic at(input int n);
		while (cyc < t0 + n) @(posedge core_clk);
	endtask

	// 0 supply, 1 pin, 2 debug port; the pin one lands mid-sequence
	task automatic cause(input int k);
		if (k == 0) supply_ok <= 1'b0;
		else if (k == 1) run_pin <= 1'b0;
		else debug_restart <= 1'b1;
		repeat (6 + ($random(seed) & 7)) @(posedge core_clk);
		chk(blk_rst_n, '0);
		chk(run_rst_n, k == 2);
		chk(dp_rst_n, k == 2);
		supply_ok     <= 1'b1;
		run_pin       <= 1'b1;
		debug_restart <= 1'b0;
		while (!run_rst_n) @(posedge core_clk);
		t0 = cyc;
		wt(BLK_CLOCKS);
		rd(ADDR_CHIP_RST, k == 0 ? 32'h1 << CR_SUPPLY_BIT : k == 1 ? 32'h1 << CR_PIN_BIT :
			(32'h1 << CR_DEBUG_BIT) | (32'h1 << CR_FLAG_BIT));
	endtask

	// the reader is a separate process so reads may run back to back
	always @(posedge core_clk) begin
		rd_d <= reg_rd;
		slow <= 1'($random(seed));
		if (rd_d && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		logic [3:0] th;
		seed = 32'h9938_5845;
		{rst_n, supply_ok, run_pin, debug_restart, watchdog_fire, reg_wr, reg_rd} = '0;
		{reg_addr, reg_wdata} = '0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		cause(0);
		at(BOD_ACTIVE_CYC - 50);
		chk(bod_active, 0);
		at(BOD_ACTIVE_CYC + 50);
		chk(bod_active, 1);
		rd(ADDR_FORCE_ON, 0);
		rd(ADDR_FORCE_OFF, 0);
		rd(ADDR_WD_SELECT, 0);
		rd(ADDR_BROWNOUT, 32'h0000_0091);
		wr(4'hE, $random(seed));
		rd(4'hE, 0);
		cause(2);
		wr(ADDR_CHIP_RST, 32'h1 << CR_FLAG_BIT);
		rd(ADDR_CHIP_RST, 32'h1 << CR_DEBUG_BIT);
		cause(1);
		at(BOD_ENABLE_CYC - 50);
		chk(bod_active, 0);
		at(BOD_ENABLE_CYC + 50);
		chk(bod_active, 1);
		wt(BLK_PROC1);
		chk(blk_rst_n, 32'h0001_FFFF);
		chk({ref_from_ring, sys_from_ref}, 3);
		chk(ring_osc_start, 1);
		wr(ADDR_DONE, 0);
		// slow blocks may need up to 13 cycles for done after release
		repeat (16) @(posedge core_clk);
		rd(ADDR_DONE, 32'h0001_FFFF);
		wr(ADDR_BROWNOUT, 32'h0000_0090);
		chk(bod_active, 0);
		wr(ADDR_BROWNOUT, 32'h0000_0091);
		t0 = cyc;
		at(BOD_ENABLE_CYC - 50);
		chk(bod_active, 0);
		at(BOD_ENABLE_CYC + 50);
		chk(bod_active, 1);
		th = $random(seed) & 7;
		wr(ADDR_BROWNOUT, {24'h0, th, 4'h1});
		t0 = cyc;
		at(BOD_PROG_CYC - 50);
		chk(bod_threshold, 4'h9);
		at(BOD_PROG_CYC + 50);
		chk(bod_threshold, th);
		wr(ADDR_WD_SELECT, 32'h1 << BLK_ROM);
		watchdog_fire <= 1'b1;
		@(posedge core_clk);
		watchdog_fire <= 1'b0;
		@(posedge core_clk);
		chk(blk_rst_n, 32'h0000_3FCF);
		chk(run_rst_n, 1);
		wt(BLK_PROC1);
		repeat (16) @(posedge core_clk);
		rd(ADDR_DONE, 32'h0001_FFFF);
		repeat (4) @(posedge core_clk);
		end_sim();
	end
endmodule

bind reset_sequencer reset_sequencer_props #(.NB(NB)) u_props (.core_clk, .rst_n,
	.supply_ok, .run_pin, .debug_restart, .watchdog_fire, .blk_done, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .blk_rst_n, .run_rst_n, .dp_rst_n,
	.bod_active, .bod_threshold, .ref_from_ring, .sys_from_ref, .ring_osc_start);
